// [core/pxr_regs.sv]
// Purpose: One port's bypass, error counter and extended control/status registers.
// Assumes: Event inputs come from PHY logic on CLK_I; the management layer decodes the port.
// Notes: Read data is registered and appears one cycle after the read strobe.
`timescale 1ns/10ps
`include "pxr_defines.svh"
module pxr_regs (
	input  wire logic              CLK_I,
	input  wire logic              ARST_N_I,
	input  wire logic              SOFT_RST_I,
	input  wire logic              PORT_MATCH_I,
	input  wire logic              BCAST_ANY_I,
	input  wire pxr_pkg::pxr_addr_t REG_ADDR_I,
	input  wire pxr_pkg::pxr_word_t REG_WDATA_I,
	input  wire logic              REG_WR_I,
	input  wire logic              REG_RD_I,
	output pxr_pkg::pxr_word_t     REG_RDATA_O,
	input  wire logic              RX_ERR_I,
	input  wire logic              FALSE_CARRIER_I,
	input  wire logic              LINK_DISC_I,
	input  wire logic              EOF_ERR_I,
	input  wire logic              TEN_DISC_I,
	input  wire logic              TEN_LINK_I,
	output logic                   TX_DISABLE_O,
	output logic                   CODER_BYPASS_O,
	output logic                   SCRAMBLER_BYPASS_O,
	output logic                   DESCRAMBLER_BYPASS_O,
	output logic                   PCS_RX_BYPASS_O,
	output logic                   PCS_TX_BYPASS_O,
	output logic                   LFI_TIMER_BYPASS_O,
	output logic                   XOVER_FORCED_DIS_O,
	output logic                   NONCOMPLIANT_DET_DIS_O,
	output logic                   PAIR_SWAP_DIS_O,
	output logic                   POLARITY_CORR_DIS_O,
	output logic                   PARALLEL_HONOUR_O,
	output logic                   PULSE_SHAPE_DIS_O,
	output logic                   AUTO_NEXT_PAGE_DIS_O,
	output logic                   FORCE_LINK_PASS_O,
	output logic                   JABBER_DIS_O,
	output logic                   ECHO_DIS_O,
	output logic                   SQE_TEST_DIS_O,
	output pxr_pkg::pxr_squelch_t  SQUELCH_O,
	output logic                   BCAST_EN_O
);

	// ************************************************************
	// Access decode.
	// ************************************************************

	logic wr_ok;
	logic rd_ok;
	logic wr_byp;
	logic wr_ext;
	logic rd_rxe;
	logic rd_fcr;
	logic rd_ldc;
	logic rd_ext;

	assign wr_ok  = REG_WR_I && (PORT_MATCH_I || BCAST_ANY_I);
	assign rd_ok  = REG_RD_I && PORT_MATCH_I;
	assign wr_byp = wr_ok && (REG_ADDR_I == `PXR_ADDR_BYPASS);
	assign wr_ext = wr_ok && (REG_ADDR_I == `PXR_ADDR_EXT);
	assign rd_rxe = rd_ok && (REG_ADDR_I == `PXR_ADDR_RXERR);
	assign rd_fcr = rd_ok && (REG_ADDR_I == `PXR_ADDR_FCAR);
	assign rd_ldc = rd_ok && (REG_ADDR_I == `PXR_ADDR_LDISC);
	assign rd_ext = rd_ok && (REG_ADDR_I == `PXR_ADDR_EXT);

	// ************************************************************
	// Control registers with sticky handling.
	// ************************************************************

	function automatic pxr_pkg::pxr_word_t soft_val(input pxr_pkg::pxr_word_t cur,
			input pxr_pkg::pxr_word_t dflt, input pxr_pkg::pxr_word_t sticky,
			input pxr_pkg::pxr_word_t super_m, input logic retain);
		pxr_pkg::pxr_word_t keep;
		keep = super_m | (retain ? sticky : 16'h0000);
		soft_val = (cur & keep) | (dflt & ~keep);
	endfunction

	function automatic pxr_pkg::pxr_word_t wr_val(input pxr_pkg::pxr_word_t cur,
			input pxr_pkg::pxr_word_t wd, input pxr_pkg::pxr_word_t mask);
		wr_val = (wd & mask) | (cur & ~mask);
	endfunction

	pxr_pkg::pxr_word_t byp_reg;
	pxr_pkg::pxr_word_t byp_next;
	pxr_pkg::pxr_word_t ext_reg;
	pxr_pkg::pxr_word_t ext_next;
	logic               retain;

	assign retain   = ext_reg[`PXR_BIT_RETAIN];
	assign byp_next = SOFT_RST_I ? soft_val(byp_reg, `PXR_BYP_RESET, `PXR_BYP_STICKY,
			`PXR_BYP_SUPER, retain) :
			wr_byp ? wr_val(byp_reg, REG_WDATA_I, `PXR_BYP_RW_MASK) : byp_reg;
	assign ext_next = SOFT_RST_I ? soft_val(ext_reg, `PXR_EXT_RESET, `PXR_EXT_STICKY,
			`PXR_EXT_SUPER, retain) :
			wr_ext ? wr_val(ext_reg, REG_WDATA_I, `PXR_EXT_RW_MASK) : ext_reg;

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			byp_reg <= `PXR_BYP_RESET;
			ext_reg <= `PXR_EXT_RESET;
		end else begin
			byp_reg <= byp_next;
			ext_reg <= ext_next;
		end
	end

	// ************************************************************
	// Control outputs.
	// ************************************************************

	assign TX_DISABLE_O           = byp_reg[15];
	assign CODER_BYPASS_O         = byp_reg[14];
	assign SCRAMBLER_BYPASS_O     = byp_reg[13];
	assign DESCRAMBLER_BYPASS_O   = byp_reg[12];
	assign PCS_RX_BYPASS_O        = byp_reg[11];
	assign PCS_TX_BYPASS_O        = byp_reg[10];
	assign LFI_TIMER_BYPASS_O     = byp_reg[9];
	assign XOVER_FORCED_DIS_O     = byp_reg[7];
	assign NONCOMPLIANT_DET_DIS_O = byp_reg[6];
	assign PAIR_SWAP_DIS_O        = byp_reg[5];
	assign POLARITY_CORR_DIS_O    = byp_reg[4];
	assign PARALLEL_HONOUR_O      = byp_reg[3];
	assign PULSE_SHAPE_DIS_O      = byp_reg[2];
	assign AUTO_NEXT_PAGE_DIS_O   = byp_reg[1];
	assign FORCE_LINK_PASS_O      = ext_reg[15];
	assign JABBER_DIS_O           = ext_reg[14];
	assign ECHO_DIS_O             = ext_reg[13];
	assign SQE_TEST_DIS_O         = ext_reg[12];
	assign SQUELCH_O              = pxr_pkg::pxr_squelch_t'(ext_reg[11:10]);
	assign BCAST_EN_O             = ext_reg[`PXR_BIT_BCAST];

	// ************************************************************
	// Error counters and self-clearing status.
	// ************************************************************

	function automatic pxr_pkg::pxr_cnt_t cnt_step(input pxr_pkg::pxr_cnt_t cnt,
			input logic ev, input logic clr);
		if (clr) begin
			cnt_step = ev ? 8'h01 : `PXR_CNT_RESET;
		end else if (ev && (cnt != `PXR_CNT_MAX)) begin
			cnt_step = cnt + 8'h01;
		end else begin
			cnt_step = cnt;
		end
	endfunction

	pxr_pkg::pxr_cnt_t rxe_reg;
	pxr_pkg::pxr_cnt_t fcr_reg;
	pxr_pkg::pxr_cnt_t ldc_reg;
	pxr_pkg::pxr_cnt_t rxe_next;
	pxr_pkg::pxr_cnt_t fcr_next;
	pxr_pkg::pxr_cnt_t ldc_next;
	logic              eof_reg;
	logic              tdisc_reg;
	logic              eof_next;
	logic              tdisc_next;

	assign rxe_next   = cnt_step(rxe_reg, RX_ERR_I, rd_rxe || SOFT_RST_I);
	assign fcr_next   = cnt_step(fcr_reg, FALSE_CARRIER_I, rd_fcr || SOFT_RST_I);
	assign ldc_next   = cnt_step(ldc_reg, LINK_DISC_I, rd_ldc || SOFT_RST_I);
	assign eof_next   = EOF_ERR_I || (eof_reg && !rd_ext && !SOFT_RST_I);
	assign tdisc_next = TEN_DISC_I || (tdisc_reg && !rd_ext && !SOFT_RST_I);

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rxe_reg   <= `PXR_CNT_RESET;
			fcr_reg   <= `PXR_CNT_RESET;
			ldc_reg   <= `PXR_CNT_RESET;
			eof_reg   <= 1'b0;
			tdisc_reg <= 1'b0;
		end else begin
			rxe_reg   <= rxe_next;
			fcr_reg   <= fcr_next;
			ldc_reg   <= ldc_next;
			eof_reg   <= eof_next;
			tdisc_reg <= tdisc_next;
		end
	end

	// ************************************************************
	// Read path.
	// ************************************************************

	pxr_pkg::pxr_word_t ext_view;
	pxr_pkg::pxr_word_t rd_sel;
	pxr_pkg::pxr_word_t rdata_reg;
	pxr_pkg::pxr_word_t rdata_next;

	assign ext_view = (ext_reg & `PXR_EXT_RW_MASK) | {7'h00, eof_reg, tdisc_reg, TEN_LINK_I,
			6'h00};
	assign rd_sel = (REG_ADDR_I == `PXR_ADDR_BYPASS) ? (byp_reg & `PXR_BYP_RW_MASK) :
			(REG_ADDR_I == `PXR_ADDR_RXERR) ? {8'h00, rxe_reg} :
			(REG_ADDR_I == `PXR_ADDR_FCAR) ? {8'h00, fcr_reg} :
			(REG_ADDR_I == `PXR_ADDR_LDISC) ? {8'h00, ldc_reg} :
			(REG_ADDR_I == `PXR_ADDR_EXT) ? ext_view : 16'h0000;
	assign rdata_next = rd_ok ? rd_sel : 16'h0000;

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rdata_reg <= 16'h0000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign REG_RDATA_O = rdata_reg;

	// ************************************************************
	// Assertions.
	// ************************************************************

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);

	a_txdis_write: assert property ((wr_byp && !SOFT_RST_I) |=>
			TX_DISABLE_O == $past(REG_WDATA_I[15]))
		else $error("Transmit disable did not follow the write.");

	a_bcast_write: assert property ((REG_WR_I && !PORT_MATCH_I && BCAST_ANY_I &&
			REG_ADDR_I == `PXR_ADDR_EXT && !SOFT_RST_I) |=>
			ext_reg == (($past(REG_WDATA_I) & `PXR_EXT_RW_MASK) |
			($past(ext_reg) & ~`PXR_EXT_RW_MASK)))
		else $error("Broadcast write was not applied.");

	a_foreign_write: assert property ((REG_WR_I && !PORT_MATCH_I && !BCAST_ANY_I &&
			!SOFT_RST_I) |=> $stable(byp_reg) && $stable(ext_reg))
		else $error("A write to another port changed this port.");

	a_foreign_read: assert property ((REG_RD_I && !PORT_MATCH_I) |=>
			REG_RDATA_O == 16'h0000 && ($stable(rxe_reg) || $past(RX_ERR_I) ||
			$past(SOFT_RST_I)))
		else $error("A read for another port returned data or cleared a counter.");

	a_cnt_saturate: assert property ((rxe_reg == `PXR_CNT_MAX && !rd_rxe &&
			!SOFT_RST_I) |=> rxe_reg == `PXR_CNT_MAX)
		else $error("Counter left saturation without a read.");

	a_cnt_rdclear: assert property ((rd_fcr && !FALSE_CARRIER_I) |=>
			fcr_reg == `PXR_CNT_RESET && REG_RDATA_O == {8'h00, $past(fcr_reg)})
		else $error("Counter read did not return and clear the count.");

	a_soft_default: assert property ((SOFT_RST_I && !retain) |=>
			byp_reg == `PXR_BYP_RESET && ext_reg[15:10] == 6'h0C)
		else $error("Sticky bits missed their defaults on software reset.");

	a_super_keep: assert property (SOFT_RST_I |=>
			ext_reg[`PXR_BIT_RETAIN] == $past(ext_reg[`PXR_BIT_RETAIN]))
		else $error("Retention enable changed on software reset.");

	a_sticky_keep: assert property ((SOFT_RST_I && retain) |=>
			(byp_reg & `PXR_BYP_STICKY) == ($past(byp_reg) & `PXR_BYP_STICKY))
		else $error("Sticky bits were lost with retention enabled.");

	a_status_setwin: assert property ((rd_ext && EOF_ERR_I) |=> eof_reg ##1
			(eof_reg || $past(rd_ext) || $past(SOFT_RST_I)))
		else $error("End-of-frame flag lost while being cleared.");

	a_reserved_zero: assert property (rd_ok |=> REG_RDATA_O[8] == 1'b0 ||
			$past(REG_ADDR_I) == `PXR_ADDR_EXT)
		else $error("Reserved bit read as one.");

	a_byp_write: assert property ((wr_byp && !SOFT_RST_I) |=>
			byp_reg == (($past(REG_WDATA_I) & `PXR_BYP_RW_MASK) |
			($past(byp_reg) & ~`PXR_BYP_RW_MASK)))
		else $error("Bypass write did not land in the writable bits.");

	a_ext_write: assert property ((wr_ext && !SOFT_RST_I) |=>
			ext_reg == (($past(REG_WDATA_I) & `PXR_EXT_RW_MASK) |
			($past(ext_reg) & ~`PXR_EXT_RW_MASK)))
		else $error("Extended control write did not land in the writable bits.");

	a_rd_idle: assert property (!rd_ok |=> REG_RDATA_O == 16'h0000)
		else $error("Read data stood without an accepted read.");

	a_cnt_step: assert property ((RX_ERR_I && !rd_rxe && !SOFT_RST_I &&
			rxe_reg != `PXR_CNT_MAX) |=> rxe_reg == $past(rxe_reg) + 8'h01)
		else $error("Counter did not count an event.");

	a_cnt_clr_event: assert property ((rd_rxe && RX_ERR_I && !SOFT_RST_I) |=>
			rxe_reg == 8'h01)
		else $error("Event during a counter read was lost.");

	a_soft_cnt_clear: assert property ((SOFT_RST_I && !RX_ERR_I &&
			!FALSE_CARRIER_I && !LINK_DISC_I) |=> rxe_reg == `PXR_CNT_RESET &&
			fcr_reg == `PXR_CNT_RESET && ldc_reg == `PXR_CNT_RESET)
		else $error("Counters were not cleared by software reset.");

	a_soft_flag_clear: assert property ((SOFT_RST_I && !EOF_ERR_I && !TEN_DISC_I) |=>
			!eof_reg && !tdisc_reg)
		else $error("Status flags were not cleared by software reset.");

	a_eof_set: assert property (EOF_ERR_I |=> eof_reg)
		else $error("End-of-frame event did not set its flag.");

	a_tdisc_set: assert property (TEN_DISC_I |=> tdisc_reg)
		else $error("Disconnect event did not set its flag.");

	a_eof_keep: assert property ((eof_reg && !rd_ext && !SOFT_RST_I) |=>
			eof_reg)
		else $error("End-of-frame flag cleared without a read.");

	a_tdisc_keep: assert property ((tdisc_reg && !rd_ext && !SOFT_RST_I) |=>
			tdisc_reg)
		else $error("Disconnect flag cleared without a read.");

	a_flag_rdclear: assert property ((rd_ext && !EOF_ERR_I && !TEN_DISC_I) |=>
			!eof_reg && !tdisc_reg && REG_RDATA_O[8:7] == $past({eof_reg, tdisc_reg}))
		else $error("Status read did not return and clear the flags.");

	a_link_live: assert property (rd_ext |=> REG_RDATA_O[6] == $past(TEN_LINK_I))
		else $error("Link status read did not show the live level.");

	a_ext_reserved: assert property (rd_ext |=> REG_RDATA_O[5:1] == 5'h00)
		else $error("Reserved status bits read as one.");

	a_cnt_upper: assert property ((rd_rxe || rd_fcr || rd_ldc) |=>
			REG_RDATA_O[15:8] == 8'h00)
		else $error("Counter upper byte read as nonzero.");

	a_byp_readback: assert property ((rd_ok && REG_ADDR_I == `PXR_ADDR_BYPASS) |=>
			REG_RDATA_O == ($past(byp_reg) & `PXR_BYP_RW_MASK))
		else $error("Bypass read did not return the stored bits.");

	a_soft_nonsticky: assert property (SOFT_RST_I |=>
			(byp_reg & ~`PXR_BYP_STICKY) == (`PXR_BYP_RESET & ~`PXR_BYP_STICKY))
		else $error("Non-sticky bits survived a software reset.");

	a_soft_bcast_dflt: assert property ((SOFT_RST_I && !retain) |=>
			ext_reg[`PXR_BIT_BCAST] == 1'b0)
		else $error("Broadcast enable missed its default on software reset.");

	a_retain_write: assert property ((wr_ext && !SOFT_RST_I) |=>
			retain == $past(REG_WDATA_I[`PXR_BIT_RETAIN]))
		else $error("Retention enable did not follow the write.");

	a_bcast_byp: assert property ((REG_WR_I && !PORT_MATCH_I && BCAST_ANY_I &&
			REG_ADDR_I == `PXR_ADDR_BYPASS && !SOFT_RST_I) |=>
			byp_reg == (($past(REG_WDATA_I) & `PXR_BYP_RW_MASK) |
			($past(byp_reg) & ~`PXR_BYP_RW_MASK)))
		else $error("Broadcast bypass write was not applied.");

	a_unmapped_write: assert property ((REG_WR_I && REG_ADDR_I != `PXR_ADDR_BYPASS &&
			REG_ADDR_I != `PXR_ADDR_EXT && !SOFT_RST_I) |=> $stable(byp_reg) && $stable(ext_reg))
		else $error("A write to an unmapped register changed a control.");

	a_unmapped_read: assert property ((rd_ok && (REG_ADDR_I < `PXR_ADDR_BYPASS ||
			REG_ADDR_I > `PXR_ADDR_EXT)) |=> REG_RDATA_O == 16'h0000)
		else $error("An unmapped register read as nonzero.");

	c_bcast_write: cover property (REG_WR_I && !PORT_MATCH_I && BCAST_ANY_I);
	c_cnt_sat: cover property (rxe_reg == `PXR_CNT_MAX ##1 rd_rxe);
	c_soft_retain: cover property (SOFT_RST_I && retain);
	c_eof_read: cover property (eof_reg && rd_ext);
	c_cnt_clr_event: cover property (rd_rxe && RX_ERR_I);

endmodule

// [pkg/pxr_defines.svh]
// Purpose: Offsets, field positions, masks and reset values of the port register group.
// Assumes: Registers are 16 bits wide and addressed by a 5-bit register number.
// Notes: Included by the core and the testbench.
// Operation
// - Bypass bit 15 set disables the line transmitter; resets to zero.
// - Bypass bits 14 to 10 bypass coder, scrambler, descrambler, receive and transmit PCS.
// - Bypass bit 9 set skips the link fail inhibit timer.
// - Sticky bypass bit 7, default one, disables crossover correction at forced speeds.
// - Sticky bypass bit 6 disables non-compliant gigabit partner detection.
// - Sticky bypass bit 5 disables automatic pair swap correction under autonegotiation.
// - Sticky bypass bit 4 disables polarity inversion correction on every subchannel.
// - Sticky bypass bit 3, default one, honours advertised ability in parallel detect.
// - Bypass bit 2 disables the transmit pulse shaping filter; resets to zero.
// - Sticky bypass bit 1 stops automatic next-page exchange after the base page.
// - Three 8-bit error counters saturate at 255, reset to zero, clear on read.
// - Extended bit 15 bypasses the link integrity machine and forces link pass.
// - Sticky extended bit 14 disables jabber detection; resets to zero.
// - Sticky extended bits 13 and 12, default one, disable echo and quality test.
// - Extended bit 9 set keeps sticky bits over software reset, else they default.
// - Super-sticky bits, the retention enable among them, always survive software reset.
// - Status bit 8 end-of-frame error, bit 7 disconnect self-clear; bit 6 live link.
// - Extended bit 0 set broadcasts every management write to all ports.
// - During broadcast, reads return only the addressed port's contents.
`ifndef PXR_DEFINES_SVH
`define PXR_DEFINES_SVH
`define PXR_ADDR_BYPASS   5'h12
`define PXR_ADDR_RXERR    5'h13
`define PXR_ADDR_FCAR     5'h14
`define PXR_ADDR_LDISC    5'h15
`define PXR_ADDR_EXT      5'h16
`define PXR_BYP_RW_MASK   16'hFEFE
`define PXR_BYP_STICKY    16'h00FA
`define PXR_BYP_SUPER     16'h0000
`define PXR_BYP_RESET     16'h0088
`define PXR_EXT_RW_MASK   16'hFE01
`define PXR_EXT_STICKY    16'hFC01
`define PXR_EXT_SUPER     16'h0200
`define PXR_EXT_RESET     16'h3200
`define PXR_CNT_RESET     8'h00
`define PXR_CNT_MAX       8'hFF
`define PXR_BIT_TXDIS     15
`define PXR_BIT_RETAIN    9
`define PXR_BIT_EOF       8
`define PXR_BIT_TDISC     7
`define PXR_BIT_TLINK     6
`define PXR_BIT_BCAST     0
`endif

// [pkg/pxr_pkg.sv]
// Purpose: Types shared by the port register group.
// Assumes: Constants come from the defines header.
// Notes: Nothing here is imported.
package pxr_pkg;
	typedef logic [15:0] pxr_word_t;
	typedef logic [7:0]  pxr_cnt_t;
	typedef logic [4:0]  pxr_addr_t;
	typedef enum logic [1:0] {
		PXR_SQ_NORMAL,
		PXR_SQ_LOW,
		PXR_SQ_HIGH,
		PXR_SQ_RSVD
	} pxr_squelch_t;
endpackage

// [testbench/pxr_host.sv]
// Purpose: Management host model issuing register reads and writes.
// Assumes: Strobes are one cycle wide and change at the falling edge.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/10ps
module pxr_host (
	input  wire logic              clk_i,
	output pxr_pkg::pxr_addr_t     addr_o,
	output pxr_pkg::pxr_word_t     wdata_o,
	output logic                   wr_o,
	output logic                   rd_o,
	input  wire pxr_pkg::pxr_word_t rdata_i
);
	// ****************************************
	// Access tasks
	// ****************************************
	initial begin
		addr_o = 5'h00;
		wdata_o = 16'h0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Writes are also how the host forces the resolved configuration.
	task automatic wr(input pxr_pkg::pxr_addr_t a, input pxr_pkg::pxr_word_t d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask
	task automatic rd(input pxr_pkg::pxr_addr_t a, output pxr_pkg::pxr_word_t d);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		d = rdata_i;
		addr_o = ~a;
	endtask
endmodule

// [testbench/pxr_regs_tb.sv]
// Purpose: Self-checking bench of one port's register group.
// Assumes: Read data is valid the cycle after the read strobe.
// Notes: Control outputs are gathered into register-shaped vectors.
`timescale 1ns/10ps
`include "pxr_defines.svh"
module pxr_regs_tb;
	logic               clk;
	logic               arst_n;
	logic               soft_rst;
	logic               match;
	logic               bcast_any;
	logic [5:0]         ev;
	logic               wr;
	logic               rd;
	pxr_pkg::pxr_addr_t addr;
	pxr_pkg::pxr_word_t wdata;
	pxr_pkg::pxr_word_t rdata;
	wire [15:0]         byp;
	wire [15:0]         ext;
	int                 error_cnt = 0;
	int                 n_tests = 0;
	// ****************************************
	// Design and host
	// ****************************************
	pxr_regs u_dut (.CLK_I(clk), .ARST_N_I(arst_n), .SOFT_RST_I(soft_rst),
		.PORT_MATCH_I(match), .BCAST_ANY_I(bcast_any), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
		.RX_ERR_I(ev[0]), .FALSE_CARRIER_I(ev[1]), .LINK_DISC_I(ev[2]),
		.EOF_ERR_I(ev[3]), .TEN_DISC_I(ev[4]), .TEN_LINK_I(ev[5]),
		.TX_DISABLE_O(byp[15]), .CODER_BYPASS_O(byp[14]), .SCRAMBLER_BYPASS_O(byp[13]),
		.DESCRAMBLER_BYPASS_O(byp[12]), .PCS_RX_BYPASS_O(byp[11]),
		.PCS_TX_BYPASS_O(byp[10]), .LFI_TIMER_BYPASS_O(byp[9]),
		.XOVER_FORCED_DIS_O(byp[7]), .NONCOMPLIANT_DET_DIS_O(byp[6]),
		.PAIR_SWAP_DIS_O(byp[5]), .POLARITY_CORR_DIS_O(byp[4]),
		.PARALLEL_HONOUR_O(byp[3]), .PULSE_SHAPE_DIS_O(byp[2]),
		.AUTO_NEXT_PAGE_DIS_O(byp[1]), .FORCE_LINK_PASS_O(ext[15]),
		.JABBER_DIS_O(ext[14]), .ECHO_DIS_O(ext[13]), .SQE_TEST_DIS_O(ext[12]),
		.SQUELCH_O(ext[11:10]), .BCAST_EN_O(ext[0]));
	assign byp[8]   = 1'b0;
	assign byp[0]   = 1'b0;
	assign ext[9:1] = 9'h000;
	pxr_host u_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
		.rdata_i(rdata));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input pxr_pkg::pxr_word_t got, input pxr_pkg::pxr_word_t exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input pxr_pkg::pxr_addr_t a, input pxr_pkg::pxr_word_t exp);
		pxr_pkg::pxr_word_t d;
		u_host.rd(a, d);
		chk(d, exp);
	endtask
	task automatic pulse(input int i, input int n);
		@(negedge clk);
		ev[i] = 1'b1;
		repeat (n) @(negedge clk);
		ev[i] = 1'b0;
	endtask
	task automatic srst();
		@(negedge clk);
		soft_rst = 1'b1;
		@(negedge clk);
		soft_rst = 1'b0;
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ****************************************
	// Clock, watchdog and sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		close_out();
	end
	initial begin
		int cnt;
		pxr_pkg::pxr_word_t cnt_exp;
		arst_n = 1'b0;
		soft_rst = 1'b0;
		match = 1'b1;
		bcast_any = 1'b0;
		ev = 6'h00;
		repeat (8) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		rdc(`PXR_ADDR_BYPASS, `PXR_BYP_RESET);
		chk(byp & `PXR_BYP_RW_MASK, 16'h0088);
		rdc(`PXR_ADDR_EXT, `PXR_EXT_RESET);
		for (int i = 0; i < 3; i++) begin
			cnt = (i == 1) ? 133 : 263;
			pulse(i, cnt);
			cnt_exp = (cnt > `PXR_CNT_MAX) ? {8'h00, `PXR_CNT_MAX} : 16'(cnt);
			rdc(pxr_pkg::pxr_addr_t'(`PXR_ADDR_RXERR + i), cnt_exp);
			rdc(pxr_pkg::pxr_addr_t'(`PXR_ADDR_RXERR + i), 16'h0000);
		end
		u_host.wr(`PXR_ADDR_BYPASS, 16'hFFFF);
		rdc(`PXR_ADDR_BYPASS, 16'hFEFE);
		chk(byp & `PXR_BYP_RW_MASK, 16'hFEFE);
		ev[5] = 1'b1;
		u_host.wr(`PXR_ADDR_EXT, 16'hFFFF);
		rdc(`PXR_ADDR_EXT, 16'hFE41);
		chk(ext & 16'hFC01, 16'hFC01);
		pulse(3, 1);
		pulse(4, 1);
		rdc(`PXR_ADDR_EXT, 16'hFFC1);
		rdc(`PXR_ADDR_EXT, 16'hFE41);
		fork
			rdc(`PXR_ADDR_EXT, 16'hFE41);
			pulse(3, 1);
		join
		rdc(`PXR_ADDR_EXT, 16'hFF41);
		u_host.wr(5'h1F, 16'hFFFF);
		rdc(5'h1F, 16'h0000);
		pulse(0, 2);
		srst();
		rdc(`PXR_ADDR_BYPASS, 16'h00FA);
		rdc(`PXR_ADDR_EXT, 16'hFE41);
		fork
			rdc(`PXR_ADDR_RXERR, 16'h0000);
			pulse(0, 1);
		join
		rdc(`PXR_ADDR_RXERR, 16'h0001);
		match = 1'b0;
		bcast_any = 1'b1;
		u_host.wr(`PXR_ADDR_BYPASS, 16'h8000);
		u_host.wr(`PXR_ADDR_EXT, 16'hFE00);
		rdc(`PXR_ADDR_BYPASS, 16'h0000);
		match = 1'b1;
		rdc(`PXR_ADDR_BYPASS, 16'h8000);
		rdc(`PXR_ADDR_EXT, 16'hFE40);
		match = 1'b0;
		bcast_any = 1'b0;
		u_host.wr(`PXR_ADDR_BYPASS, 16'h0000);
		match = 1'b1;
		rdc(`PXR_ADDR_BYPASS, 16'h8000);
		u_host.wr(`PXR_ADDR_EXT, 16'h0000);
		srst();
		rdc(`PXR_ADDR_BYPASS, `PXR_BYP_RESET);
		rdc(`PXR_ADDR_EXT, 16'h3040);
		chk(ext & 16'hFC01, 16'h3000);
		u_host.wr(`PXR_ADDR_BYPASS, 16'h0002);
		chk(byp & `PXR_BYP_RW_MASK, 16'h0002);
		close_out();
	end
endmodule
